// *** field_limit_irq_config.sv ***
/*
 * Limit check and interrupt configuration registers behind a serial
 * two-wire target port, with crossing counter and interrupt output.
 * Assumes: conversion results arrive on sys_clk with a done pulse;
 * scl/sda/int pins are open drain, resolved by the surroundings.
 */
// Contract
// (R1) Limit interrupt after one crossing if count bit 0, four if 1.
// (R2) Direction bit flags above (0) or below (1); ignored for band above 1.
// (R3) Gain channel bit picks first (0) or second (1) axis of pair.
// (R4) Angle pair field: 0 off, 1 X-Y, 2 Y-Z, 3 X-Z.
// (R5) Planar range bit picks lower or doubled X/Y range.
// (R6) Vertical range bit picks lower or doubled Z range.
// (R7) X/Y limits are signed 8-bit codes scaled by planar range.
// (R8) Limit step is range over 128, doubled when range bit set.
// (R9) A zero limit disables that channel's comparison.
// (R10) Z limit is signed code scaled by vertical range.
// (R11) Temperature limit uses 7-bit code, 8 degrees per step.
// (R12) Temperature channel bit adds temperature to conversions.
// (R13) Result enable raises interrupt when conversion set completes.
// (R14) Limit enable raises interrupt on crossing; otherwise none.
// (R15) Latched until addressed, or single 10 us pulse.
// (R16) Band select: signed limit, symmetric magnitude, or 8..256 LSB bands.
// (R17) Mode routes interrupt to int pin or scl, or switch output.
// (R18) Check per completed conversion; counter clears on interrupt or write.
`timescale 1ns/100ps
`default_nettype none
`include "field_limit_params.svh"
module field_limit_irq_config
	import field_limit_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `I2C_ADDR_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	output logic int_o,
	output logic int_oe,
	input wire logic conv_done,
	input wire logic [2:0] band_select,
	input wire logic [2:0] mag_ch_on,
	input wire field_t x_field,
	input wire field_t y_field,
	input wire field_t z_field,
	input wire logic [6:0] temp_code,
	output logic [1:0] angle_pair,
	output logic angle_on,
	output logic [2:0] gain_axis,
	output logic xy_range_wide,
	output logic z_range_wide,
	output logic temperature_channel_on
);
	localparam int PULSE_CYC = `IRQ_PULSE_NS / `SYS_CLK_NS;

	typedef struct packed {
		bus_state_e st;
		logic [3:0] bits;
		logic [7:0] sh;
		logic [7:0] ptr;
		logic rw;
		logic sda_oe;
		logic busy;
		logic scl_p;
		logic sda_p;
		logic [7:0] aoc;
		logic [7:0] xl;
		logic [7:0] yl;
		logic [7:0] zl;
		logic [7:0] tc;
		logic [7:0] irc;
		logic [2:0] cnt;
		logic latch;
		logic [11:0] pcnt;
		logic sw;
	} state_s;
	state_s q, d;

	logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c, full;
	logic addr_hit, wr_en, cfg_wr, hit_any, temp_hit, cross_ev, lim_fire;
	logic rslt_ev, irq_ev, pulse_on, active, sw_sel_hit, sw_sel_rel;
	logic [2:0] need, beyond, rel;
	logic [7:0] rd_data;
	irq_mode_e mode;
	field_t fields [3];
	logic [7:0] codes [3];
	logic wides [3];

	pin_sync #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin_in({scl_i, sda_i}),
		.pin_out({scl_s, sda_s})
	);

	// per-axis operands, z uses its own range bit
	assign fields[0] = x_field;
	assign fields[1] = y_field;
	assign fields[2] = z_field;
	assign codes[0] = q.xl;
	assign codes[1] = q.yl;
	assign codes[2] = q.zl;
	assign wides[0] = q.aoc[`AOC_XYR]; // R5 R7
	assign wides[1] = q.aoc[`AOC_XYR]; // R5
	assign wides[2] = q.aoc[`AOC_ZR]; // R6 R10
	assign mode = irq_mode_e'(q.irc[`IRC_MODE_HI:`IRC_MODE_LO]);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_axis
			limit_compare u_cmp (
				.field(fields[gi]),
				.code(codes[gi]),
				.wide(wides[gi]),
				.band(band_select), // R16
				.below(q.aoc[`AOC_DIR]),
				.omni(mode == SW_OMNI),
				.beyond(beyond[gi]),
				.release_hit(rel[gi])
			);
		end
	endgenerate

	// bus edge and condition detection
	assign scl_rise = scl_s && !q.scl_p;
	assign scl_fall = !scl_s && q.scl_p;
	assign start_c = scl_s && q.scl_p && q.sda_p && !sda_s;
	assign stop_c = scl_s && q.scl_p && !q.sda_p && sda_s;
	assign full = (q.bits == 4'h8);

	// register read mux, reserved bits read zero
	always_comb begin
		unique case (q.ptr)
			`REG_AXIS_OPT: rd_data = q.aoc;
			`REG_X_LIM: rd_data = q.xl;
			`REG_Y_LIM: rd_data = q.yl;
			`REG_Z_LIM: rd_data = q.zl;
			`REG_TEMP: rd_data = q.tc;
			`REG_IRQ: rd_data = q.irc;
			default: rd_data = `REG_RESET;
		endcase
	end

	// limit events once per completed conversion set
	assign temp_hit = (q.tc[`TC_LIM_HI:`TC_LIM_LO] != 7'h00) &&
		(temp_code > q.tc[`TC_LIM_HI:`TC_LIM_LO]); // R9 R11
	assign hit_any = |(beyond & mag_ch_on) || (temp_hit && q.tc[`TC_ON]);
	assign cross_ev = conv_done && hit_any; // R18
	assign need = q.aoc[`AOC_CNT] ? `CROSS_FOUR : `CROSS_ONE; // R1
	assign lim_fire = cross_ev && ((q.cnt + 3'h1) >= need); // R1
	assign rslt_ev = conv_done && q.irc[`IRC_RSLT]; // R13
	assign irq_ev = rslt_ev || (lim_fire && q.irc[`IRC_LIM]); // R14
	assign pulse_on = (q.pcnt != 12'h000);
	assign active = q.irc[`IRC_PULSE] ? pulse_on : q.latch; // R15

	// switch follows first enabled axis in X, Y, Z order
	always_comb begin
		sw_sel_hit = 1'b0;
		sw_sel_rel = 1'b0;
		if (mag_ch_on[0] && q.xl != `REG_RESET) begin
			sw_sel_hit = beyond[0];
			sw_sel_rel = rel[0];
		end else if (mag_ch_on[1] && q.yl != `REG_RESET) begin
			sw_sel_hit = beyond[1];
			sw_sel_rel = rel[1];
		end else if (mag_ch_on[2] && q.zl != `REG_RESET) begin
			sw_sel_hit = beyond[2];
			sw_sel_rel = rel[2];
		end
	end

	// serial target, register file and interrupt state
	always_comb begin
		d = q;
		addr_hit = 1'b0;
		wr_en = 1'b0;
		d.scl_p = scl_s;
		d.sda_p = sda_s;
		if (start_c) begin
			d.st = ST_ADDR;
			d.bits = 4'h0;
			d.busy = 1'b1;
			d.sda_oe = 1'b0;
		end else if (stop_c) begin
			d.st = ST_IDLE;
			d.busy = 1'b0;
			d.sda_oe = 1'b0;
		end else if (scl_rise) begin
			if (q.st inside {ST_ADDR, ST_PTR, ST_WDAT}) begin
				d.sh = {q.sh[6:0], sda_s};
				d.bits = q.bits + 4'h1;
			end else if (q.st == ST_RDAT) begin
				d.bits = q.bits + 4'h1;
			end else if (q.st == ST_RACK) begin
				d.rw = !sda_s; // rw reused as controller ack
			end
		end else if (scl_fall) begin
			unique case (q.st)
				ST_ADDR: if (full) begin
					if (q.sh[7:1] == DEV_ADDR) begin
						addr_hit = 1'b1;
						d.st = ST_AACK;
						d.sda_oe = 1'b1;
						d.rw = q.sh[0];
					end else begin
						d.st = ST_IDLE;
					end
				end
				ST_AACK, ST_RACK: begin
					d.bits = 4'h0;
					if (q.rw) begin
						d.st = ST_RDAT;
						d.sh = rd_data;
						d.sda_oe = !rd_data[7];
					end else begin
						d.st = (q.st == ST_AACK) ? ST_PTR : ST_IDLE;
						d.sda_oe = 1'b0;
					end
				end
				ST_PTR: if (full) begin
					d.st = ST_PACK;
					d.ptr = q.sh;
					d.sda_oe = 1'b1;
				end
				ST_PACK, ST_WACK: begin
					d.st = ST_WDAT;
					d.bits = 4'h0;
					d.sda_oe = 1'b0;
				end
				ST_WDAT: if (full) begin
					wr_en = 1'b1;
					d.st = ST_WACK;
					d.sda_oe = 1'b1;
					d.ptr = q.ptr + 8'h01;
				end
				ST_RDAT: begin
					if (full) begin
						d.st = ST_RACK;
						d.sda_oe = 1'b0;
						d.ptr = q.ptr + 8'h01;
					end else begin
						d.sh = {q.sh[6:0], 1'b0};
						d.sda_oe = !q.sh[6];
					end
				end
				default: d.st = q.st;
			endcase
		end
		// register writes, reserved bits held at zero
		cfg_wr = 1'b0;
		if (wr_en) begin
			cfg_wr = 1'b1;
			unique case (q.ptr)
				`REG_AXIS_OPT: d.aoc = q.sh & `AOC_WMASK;
				`REG_X_LIM: d.xl = q.sh;
				`REG_Y_LIM: d.yl = q.sh;
				`REG_Z_LIM: d.zl = q.sh;
				`REG_TEMP: d.tc = q.sh;
				`REG_IRQ: d.irc = q.sh & `IRC_WMASK;
				default: cfg_wr = 1'b0;
			endcase
		end
		// crossing counter clears on fire or on config write
		if (cfg_wr || lim_fire) begin
			d.cnt = 3'h0; // R18
		end else if (cross_ev) begin
			d.cnt = q.cnt + 3'h1; // R1
		end
		// latch: a new event beats the clear by addressing
		if (irq_ev) begin
			d.latch = 1'b1; // R15
		end else if (addr_hit || q.irc[`IRC_PULSE]) begin
			d.latch = 1'b0; // R15
		end
		if (irq_ev && q.irc[`IRC_PULSE]) begin
			d.pcnt = 12'(PULSE_CYC); // R15
		end else if (pulse_on) begin
			d.pcnt = q.pcnt - 12'h001;
		end
		// switch state, with hysteresis only for band select above 1, updated per conversion
		if (conv_done && sw_sel_hit) begin
			d.sw = 1'b1;
		end else if (conv_done && sw_sel_rel) begin
			d.sw = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{st: ST_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

	// interrupt routing by mode, pins drive low only
	always_comb begin
		int_oe = 1'b0;
		scl_oe = 1'b0;
		unique case (mode)
			IRQ_PIN: int_oe = active; // R17
			IRQ_PIN_IDLE: int_oe = active && !q.busy; // R17
			IRQ_SCL: scl_oe = active; // R17
			IRQ_SCL_IDLE: scl_oe = active && !q.busy; // R17
			SW_UNI, SW_OMNI: int_oe = q.sw; // R17
			IRQ_NONE, IRQ_BAD: int_oe = 1'b0;
		endcase
	end
	assign int_o = 1'b0;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign sda_oe = q.sda_oe;

	// configuration outputs to the datapath
	assign angle_pair = q.aoc[`AOC_PAIR_HI:`AOC_PAIR_LO]; // R4
	assign angle_on = (angle_pair != 2'h0); // R4
	always_comb begin
		unique case (angle_pair)
			2'h1: gain_axis = q.aoc[`AOC_GAIN] ? 3'h2 : 3'h1; // R3
			2'h2: gain_axis = q.aoc[`AOC_GAIN] ? 3'h4 : 3'h2; // R3
			2'h3: gain_axis = q.aoc[`AOC_GAIN] ? 3'h4 : 3'h1; // R3
			default: gain_axis = 3'h0; // R4
		endcase
	end
	assign xy_range_wide = q.aoc[`AOC_XYR]; // R5
	assign z_range_wide = q.aoc[`AOC_ZR]; // R6
	assign temperature_channel_on = q.tc[`TC_ON]; // R12

	// checks
	sequence seq_cross;
		conv_done && hit_any;
	endsequence
	sequence seq_latched_hold;
		q.latch && !addr_hit && !q.irc[`IRC_PULSE];
	endsequence
	property p_one_cross;
		@(posedge sys_clk) disable iff (!rst_n)
		seq_cross and (!q.aoc[`AOC_CNT] && q.irc[`IRC_LIM] && !q.irc[`IRC_PULSE])
		|=> q.latch;
	endproperty
	AST_ONE_CROSS: assert property (p_one_cross) else $error("single crossing missed"); // R1
	AST_FOUR_COUNT: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(seq_cross and (q.aoc[`AOC_CNT] && q.cnt < 3'h3 && !cfg_wr))
		|=> q.cnt == $past(q.cnt) + 3'h1) else $error("count not advanced"); // R1
	AST_FOURTH_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(seq_cross and (q.aoc[`AOC_CNT] && q.cnt == 3'h3)) |=> q.cnt == 3'h0)
		else $error("counter kept after fire"); // R18
	AST_NO_LIM_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!q.irc[`IRC_LIM] && !q.irc[`IRC_RSLT] && !q.latch) |=> !q.latch)
		else $error("interrupt without enable"); // R14
	AST_RESULT_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(conv_done && q.irc[`IRC_RSLT] && !q.irc[`IRC_PULSE]) |=> q.latch ##1 1'b1)
		else $error("result interrupt missed"); // R13
	AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		seq_latched_hold |=> q.latch) else $error("latch dropped"); // R15
	AST_PULSE_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(pulse_on) |-> pulse_on [*8]) else $error("pulse too short"); // R15
	AST_ZERO_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(q.xl == `REG_RESET) |-> !beyond[0]) else $error("zero limit compared"); // R9
	AST_ANGLE_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(q.aoc[`AOC_PAIR_HI:`AOC_PAIR_LO] == 2'h0) |-> (!angle_on && gain_axis == 3'h0))
		else $error("pair off but active"); // R4
endmodule
`default_nettype wire

// *** field_limit_params.svh ***
/*
 * Register offsets, field positions, reset values and timing figures
 * for the limit check and interrupt configuration block.
 * Assumes: included by bare name; holds definitions only.
 */
`ifndef FIELD_LIMIT_PARAMS_SVH
`define FIELD_LIMIT_PARAMS_SVH
// register offsets on the serial port
`define REG_AXIS_OPT 8'h03
`define REG_X_LIM 8'h04
`define REG_Y_LIM 8'h05
`define REG_Z_LIM 8'h06
`define REG_TEMP 8'h07
`define REG_IRQ 8'h08
`define REG_RESET 8'h00
// axis_option_control fields
`define AOC_CNT 6
`define AOC_DIR 5
`define AOC_GAIN 4
`define AOC_PAIR_HI 3
`define AOC_PAIR_LO 2
`define AOC_XYR 1
`define AOC_ZR 0
`define AOC_WMASK 8'h7f
// temperature_control fields
`define TC_LIM_HI 7
`define TC_LIM_LO 1
`define TC_ON 0
// irq_response_control fields
`define IRC_RSLT 7
`define IRC_LIM 6
`define IRC_PULSE 5
`define IRC_MODE_HI 4
`define IRC_MODE_LO 2
`define IRC_WMASK 8'hfd
// scaling: code step is 2048/128 counts of the lower range
`define LIM_SHIFT 3'h4
`define BAND_BASE 16'h0008
`define BAND_SIGNED 3'h0
`define BAND_MAG 3'h1
`define BAND_OFS 4'h2
// crossing counts
`define CROSS_ONE 3'h1
`define CROSS_FOUR 3'h4
// timing
`define SYS_CLK_NS 4
`define IRQ_PULSE_NS 10000
`define I2C_ADDR_DEF 7'h35
`endif

// *** field_limit_pkg.sv ***
/*
 * Types shared by the limit check block: field sample type, interrupt
 * route codes and serial target states.
 * Assumes: compiled before every module that imports it.
 */
`default_nettype none
package field_limit_pkg;
	typedef logic signed [13:0] field_t;
	typedef enum logic [2:0] {
		IRQ_NONE = 3'h0, IRQ_PIN = 3'h1, IRQ_PIN_IDLE = 3'h2, IRQ_SCL = 3'h3,
		IRQ_SCL_IDLE = 3'h4, SW_UNI = 3'h5, SW_OMNI = 3'h6, IRQ_BAD = 3'h7
	} irq_mode_e;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_AACK = 9'h004, ST_PTR = 9'h008,
		ST_PACK = 9'h010, ST_WDAT = 9'h020, ST_WACK = 9'h040, ST_RDAT = 9'h080,
		ST_RACK = 9'h100
	} bus_state_e;
endpackage
`default_nettype wire

// *** i2c_ctrl_model.sv ***
/*
 * Behavioural two-wire bus controller driving the register port.
 * Assumes: both lines pulled up by the bench; paced by sys_clk, 80 ns bit.
 */
`timescale 1ns/100ps
`default_nettype none
module i2c_ctrl_model #(
	parameter logic [6:0] ADDR = 7'h35
) (
	input wire logic sys_clk,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	logic all_ack;
	// lines released, clock parked high outside frames
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		all_ack = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// data set while scl low, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		sda_oe <= !b;
		tick(5);
		scl_oe <= 1'b0;
		tick(5);
		r = sda;
		tick(5);
		scl_oe <= 1'b1;
		tick(5);
	endtask
	// start or repeated start, ends with scl low
	task automatic start();
		sda_oe <= 1'b0;
		tick(5);
		scl_oe <= 1'b0;
		tick(5);
		sda_oe <= 1'b1;
		tick(5);
		scl_oe <= 1'b1;
		tick(5);
	endtask
	task automatic stop();
		sda_oe <= 1'b1;
		tick(5);
		scl_oe <= 1'b0;
		tick(5);
		sda_oe <= 1'b0;
		tick(10);
	endtask
	// byte msb first, ninth bit released (last) or acknowledged
	task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
		output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], b);
			r[i] = b;
		end
		bit_io(last, b);
		ack = !b;
	endtask
	task automatic put(input logic [7:0] w);
		logic [7:0] r;
		logic ack;
		xfer(w, 1'b1, r, ack);
		if (!ack) all_ack = 1'b0;
	endtask
	// address only frame, clears a latched interrupt when acked
	task automatic probe(input logic [6:0] a, output logic ack);
		logic [7:0] r;
		start();
		xfer({a, 1'b0}, 1'b1, r, ack);
		stop();
	endtask
	task automatic wr6(input logic [7:0] ptr, input logic [47:0] d);
		start();
		put({ADDR, 1'b0});
		put(ptr);
		for (int i = 5; i >= 0; i--) put(d[i*8+:8]);
		stop();
	endtask
	task automatic rd6(input logic [7:0] ptr, output logic [47:0] d);
		logic ack;
		start();
		put({ADDR, 1'b0});
		put(ptr);
		start();
		put({ADDR, 1'b1});
		for (int i = 5; i >= 0; i--) xfer(8'hff, i == 0, d[i*8+:8], ack);
		stop();
	endtask
endmodule
`default_nettype wire

// *** limit_compare.sv ***
/*
 * One axis limit check: scales the limit code by the axis range and
 * tests a field sample against it in the selected band mode.
 * Assumes: field sample is in counts of the lower range (2048 = full).
 */
`timescale 1ns/100ps
`default_nettype none
`include "field_limit_params.svh"
module limit_compare
	import field_limit_pkg::*;
(
	input wire field_t field,
	input wire logic [7:0] code,
	input wire logic wide,
	input wire logic [2:0] band,
	input wire logic below,
	input wire logic omni,
	output logic beyond,
	output logic release_hit
);
	logic [2:0] shamt;
	logic [3:0] bshift;
	logic signed [15:0] r, a, lim, mag, bw;

	// scale the code and test the sample
	always_comb begin
		shamt = wide ? (`LIM_SHIFT + 3'h1) : `LIM_SHIFT; // R8
		r = {{2{field[13]}}, field};
		a = (r < 0) ? -r : r;
		lim = $signed({{8{code[7]}}, code}) <<< shamt; // R7 R10
		mag = $signed({9'h000, code[6:0]}) <<< shamt;
		bshift = {1'b0, band} - `BAND_OFS + {3'h0, wide};
		bw = `BAND_BASE << bshift;
		beyond = 1'b0;
		release_hit = 1'b1;
		if (code == `REG_RESET) begin
			beyond = 1'b0; // R9
		end else if (band == `BAND_SIGNED) begin
			beyond = below ? (r < lim) : (r > lim); // R2 R16
			release_hit = !beyond;
		end else if (band == `BAND_MAG) begin
			beyond = below ? (a < mag) : (a > mag); // R16
			release_hit = !beyond;
		end else begin
			// direction ignored, band around the limit
			beyond = (omni ? a : r) > (lim + bw); // R2 R16
			release_hit = (omni ? a : r) < (lim - bw);
		end
	end
endmodule
`default_nettype wire

// *** pin_sync.sv ***
/*
 * Two-stage synchroniser for pins sampled by sys_clk.
 * Assumes: only the second stage is read by other logic.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int W = 2
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} sync_s;
	sync_s st_q, st_d;

	// shift the pins through two flops
	always_comb begin
		st_d.meta = pin_in;
		st_d.sync = st_q.meta;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign pin_out = st_q.sync;
endmodule
`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench: registers over the serial port, limit checks,
 * crossing count, latched and pulsed interrupt.
 * Assumes: open-drain lines resolved here with pull-ups.
 */
`timescale 1ns/100ps
`default_nettype none
`include "field_limit_params.svh"
module tb_top;
	import field_limit_pkg::*;
	localparam logic [6:0] ADDR = `I2C_ADDR_DEF;
	typedef struct packed {
		logic [7:0] aoc, xc, zc, tc, irq;
		logic signed [15:0] dx, dz;
		logic [6:0] t;
		logic hit;
	} case_s;
	logic sys_clk, rst_n, conv_done, scl, sda, m_scl_oe, m_sda_oe, scl_oe, sda_oe, int_oe;
	logic xy_w, z_w, t_on, a_on, ack, int_lv, scl_lv, sda_lv;
	logic [2:0] band_select;
	logic [1:0] a_pair;
	logic [2:0] mag_ch_on, g_axis;
	logic [6:0] temp_code;
	logic [47:0] d, r;
	field_t x_field, y_field, z_field;
	int errors, comparisons, cycles, n;
	case_s c;
	case_s cases[18] = '{
		'{8'h00, 8'h0a, 8'h00, 8'h00, 8'h44, 16'sd1, 16'sd0, 7'h00, 1'b1},
		'{8'h00, 8'h0a, 8'h00, 8'h00, 8'h44, -16'sd1, 16'sd0, 7'h00, 1'b0},
		'{8'h02, 8'h0a, 8'h00, 8'h00, 8'h44, -16'sd150, 16'sd0, 7'h00, 1'b0},
		'{8'h02, 8'h0a, 8'h00, 8'h00, 8'h44, 16'sd1, 16'sd0, 7'h00, 1'b1},
		'{8'h20, 8'h0a, 8'h00, 8'h00, 8'h44, -16'sd1, 16'sd0, 7'h00, 1'b1},
		'{8'h20, 8'h0a, 8'h00, 8'h00, 8'h44, 16'sd1, 16'sd0, 7'h00, 1'b0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 16'sd2000, 16'sd0, 7'h00, 1'b0},
		'{8'h20, 8'h80, 8'h00, 8'h00, 8'h44, -16'sd1, 16'sd0, 7'h00, 1'b1},
		'{8'h00, 8'h7f, 8'h00, 8'h00, 8'h44, 16'sd1, 16'sd0, 7'h00, 1'b1},
		'{8'h21, 8'h00, 8'hf6, 8'h00, 8'h44, 16'sd0, -16'sd1, 7'h00, 1'b1},
		'{8'h22, 8'h00, 8'hf6, 8'h00, 8'h44, 16'sd0, -16'sd1, 7'h00, 1'b1},
		'{8'h21, 8'h00, 8'hf6, 8'h00, 8'h44, 16'sd0, 16'sd150, 7'h00, 1'b0},
		'{8'h00, 8'h0a, 8'h00, 8'h00, 8'h04, 16'sd1, 16'sd0, 7'h00, 1'b0},
		'{8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 16'sd0, 16'sd0, 7'h00, 1'b1},
		'{8'h00, 8'h00, 8'h00, 8'h35, 8'h44, 16'sd0, 16'sd0, 7'h1b, 1'b1},
		'{8'h00, 8'h00, 8'h00, 8'h35, 8'h44, 16'sd0, 16'sd0, 7'h1a, 1'b0},
		'{8'h00, 8'h00, 8'h00, 8'h34, 8'h44, 16'sd0, 16'sd0, 7'h1b, 1'b0},
		'{8'h00, 8'h0a, 8'h00, 8'h00, 8'h40, 16'sd1, 16'sd0, 7'h00, 1'b0}
	};
	// pull-ups on both bus lines
	assign scl = !(m_scl_oe || scl_oe);
	assign sda = !(m_sda_oe || sda_oe);
	field_limit_irq_config #(.DEV_ADDR(ADDR)) u_field_limit_irq_config (
		.sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl), .scl_o(scl_lv), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(sda_lv), .sda_oe(sda_oe), .int_o(int_lv), .int_oe(int_oe),
		.conv_done(conv_done), .band_select(band_select), .mag_ch_on(mag_ch_on),
		.x_field(x_field),
		.y_field(y_field), .z_field(z_field), .temp_code(temp_code),
		.angle_pair(a_pair), .angle_on(a_on), .gain_axis(g_axis),
		.xy_range_wide(xy_w), .z_range_wide(z_w), .temperature_channel_on(t_on)
	);
	i2c_ctrl_model #(.ADDR(ADDR)) u_i2c_ctrl_model (
		.sys_clk(sys_clk), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe)
	);
	// limit in counts: code times 16, doubled in the wide range
	function automatic int lim(logic [7:0] code, logic wide);
		return $signed(code) * 16 * (wide ? 2 : 1);
	endfunction
	function automatic logic [2:0] gain_exp(logic [1:0] p, logic g);
		case (p)
			2'h1: return g ? 3'h2 : 3'h1;
			2'h2: return g ? 3'h4 : 3'h2;
			2'h3: return g ? 3'h4 : 3'h1;
			default: return 3'h0;
		endcase
	endfunction
	task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	// one conversion set; returns just after the latch edge
	task automatic conv(input field_t x, input field_t z, input logic [6:0] t);
		@(posedge sys_clk);
		x_field <= x;
		y_field <= field_t'($urandom);
		z_field <= z;
		temp_code <= t;
		mag_ch_on <= 3'h5 | 3'($urandom % 2 * 2);
		conv_done <= 1'b1;
		@(posedge sys_clk);
		conv_done <= 1'b0;
		#1;
	endtask
	task automatic final_report();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = !sys_clk;
	end
	// hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 95000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		rst_n = 1'b0;
		conv_done = 1'b0;
		mag_ch_on = 3'h0;
		band_select = 3'h0;
		temp_code = 7'h00;
		x_field = '0;
		y_field = '0;
		z_field = '0;
		void'($urandom(32'heb7f4e30));
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge sys_clk);
		u_i2c_ctrl_model.rd6(8'h03, r);
		check(r, 48'h0, "reset values");
		check({a_on, g_axis, xy_w, z_w, t_on}, 7'h0, "reset outputs");
		check({int_lv, scl_lv, sda_lv}, 3'h0, "open drain levels");
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = 48'({$urandom, $urandom});
			d[45:42] = 4'(i);
			u_i2c_ctrl_model.wr6(8'h03, d);
			u_i2c_ctrl_model.rd6(8'h03, r);
			check(r, d & 48'h7f_ff_ff_ff_ff_fd, "read back");
			check(a_pair, d[43:42], "pair");
			check(a_on, |d[43:42], "angle on");
			check(g_axis, gain_exp(d[43:42], d[44]), "gain axis");
			check({xy_w, z_w, t_on}, {d[41:40], d[8]}, "ranges");
		end
		u_i2c_ctrl_model.wr6(8'h09, 48'h5a_a5_ff_0f_f0_33);
		u_i2c_ctrl_model.rd6(8'h09, r);
		check(r, 48'h0, "unmapped");
		check(u_i2c_ctrl_model.all_ack, 1'b1, "acks");
		$display("test registers done");
		foreach (cases[i]) begin
			c = cases[i];
			u_i2c_ctrl_model.wr6(8'h03, {c.aoc, c.xc, 8'h00, c.zc, c.tc, c.irq});
			conv(field_t'(lim(c.xc, c.aoc[1]) + c.dx), field_t'(lim(c.zc, c.aoc[0]) + c.dz),
				c.t);
			check(int_oe, c.hit, "limit case");
		end
		$display("test limits done");
		u_i2c_ctrl_model.wr6(8'h03, 48'h00_0a_00_00_00_44);
		conv(field_t'(161), '0, 7'h00);
		repeat (100) @(posedge sys_clk);
		check(int_oe, 1'b1, "latched");
		u_i2c_ctrl_model.probe(ADDR ^ 7'h01, ack);
		check({ack, int_oe}, 2'b01, "other address");
		u_i2c_ctrl_model.probe(ADDR, ack);
		check({ack, int_oe}, 2'b10, "cleared");
		$display("test latch done");
		u_i2c_ctrl_model.wr6(8'h03, 48'h40_0a_00_00_00_44);
		for (int k = 1; k <= 4; k++) begin
			conv(field_t'(161), '0, 7'h00);
			check(int_oe, k == 4, "four crossings");
		end
		$display("test count done");
		for (int m = 0; m < 2; m++) begin
			u_i2c_ctrl_model.wr6(8'h03, {40'h00_0a_00_00_00, m ? 8'h6c : 8'h64});
			conv(field_t'(161), '0, 7'h00);
			n = 0;
			while ((m ? scl_oe : int_oe) === 1'b1 && n < 3000) begin
				@(posedge sys_clk);
				#1;
				n++;
			end
			check(n, 2500, "pulse length");
			check(int_oe, 1'b0, "no latch after pulse");
		end
		$display("test pulse done");
		// band mode: switch outputs, then a banded limit interrupt
		band_select <= 3'h2;
		for (int s = 0; s < 2; s++) begin
			u_i2c_ctrl_model.wr6(8'h03, {40'h00_0a_00_00_00, s ? 8'h18 : 8'h14});
			conv(field_t'(s ? -150 : 150), '0, 7'h00);
			check(int_oe, 1'b0, "switch release");
			conv(field_t'(s ? -169 : 169), '0, 7'h00);
			check(int_oe, 1'b1, "switch operate");
		end
		u_i2c_ctrl_model.wr6(8'h03, 48'h00_0a_00_00_00_44);
		conv(field_t'(165), '0, 7'h00);
		check(int_oe, 1'b0, "inside band");
		conv(field_t'(169), '0, 7'h00);
		check(int_oe, 1'b1, "beyond band");
		$display("test band done");
		final_report();
	end
endmodule
`default_nettype wire
